// ==== src/pcg_top.sv ====
// The implementer's own choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/100ps
`include "pcg_regs.svh"
// Notes on behaviour
// - Carrier starts at zero and sweeps full range; modulation is a fraction of it.
// - Carrier is sawtooth ramp or symmetric up-down triangle, by control bit.
// - Positive sequence starts active at underflow; negative starts passive.
// - Negative pattern equals positive pattern shifted by half a carrier period.
// - Variable sequence picks positive when signed select value exceeds zero.
// - Conversion and task triggers fire at underflow, overflow or both.
// - Regular sequences: modulation sets fraction of period output is active.
// - Action-table modes: inputs set first and second compare values.
// - Action-table word defines output actions at timebase and compare events.
// - Word copied to both channels, other channel's compare actions masked.
// - Second channel action table drives outputs only in dual mode.
// - Complementary mode drives inverse pair with dead time between edges.
// - Single mode modulates first channel only and releases second pin.
// - Dual mode modulates channels independently from separate inputs.
// - Disabled mode drives no pulses and releases both pins.
// - Dead time is gap between pair edges; single mode turn-on delay.
// - Variable dead time uses one shared pair or one pair per channel.
// - With variable dead time a minimum bounds applied delays from below.
// - Polarity selects which pin level means active.
// - Enable value zero forces passive outputs; ignored in action-table modes.
// - Phase loads on sync: a rising external sync edge, when enabled.
// - Each trigger divides qualifying events, firing after configured count.
// - With protection coupling, interlock trip overrides outputs to passive.
module pcg_top
  import pcg_pkg::*;
#(
  parameter int unsigned SYS_CLK_HZ = `PCG_SYS_CLK_HZ,
  parameter int unsigned CARRIER_HZ = `PCG_CARRIER_HZ
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  input  wire logic [5:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic        i_sync,
  input  wire logic        i_prot_trip,
  output logic             o_ch_a,
  output logic             o_ch_a_oe,
  output logic             o_ch_b,
  output logic             o_ch_b_oe,
  output logic             o_adc_trig,
  output logic             o_task_trig,
  output logic             o_sync_out
);
  // Rounded period count from clock and carrier rate
  function automatic logic [15:0] round_div(input int unsigned num, input int unsigned den);
    int unsigned q;
    q = (num + den / 2) / den;
    return q[15:0];
  endfunction

  // Fraction (16-bit) of a span
  function automatic logic [15:0] scale(input logic [15:0] frac, input logic [15:0] span);
    logic [31:0] p;
    p = frac * span;
    return p[31:16];
  endfunction

  // One action applied to a channel level
  function automatic logic apply(input logic cur, input logic [1:0] act);
    case (pcg_act_t'(act))
      PCG_ACT_CLR: return 1'b0;
      PCG_ACT_SET: return 1'b1;
      PCG_ACT_TGL: return ~cur;
      default:     return cur;
    endcase
  endfunction

  // Apply actions in event order, later events win
  function automatic logic act_step(input logic cur, input logic [11:0] w,
                                    input logic [5:0] ev);
    logic v;
    v = cur;
    if (ev[0]) v = apply(v, w[`PCG_ACT_ZRO]);
    if (ev[1]) v = apply(v, w[`PCG_ACT_PRD]);
    if (ev[2]) v = apply(v, w[`PCG_ACT_CAU]);
    if (ev[3]) v = apply(v, w[`PCG_ACT_CAD]);
    if (ev[4]) v = apply(v, w[`PCG_ACT_CBU]);
    if (ev[5]) v = apply(v, w[`PCG_ACT_CBD]);
    return v;
  endfunction

  // Regular pattern: active level for one compare value
  function automatic logic pattern(input logic [15:0] cnt, input logic [15:0] cmp,
                                   input logic neg, input logic tri_s,
                                   input logic [15:0] top, input logic [15:0] half);
    logic [15:0] s;
    s = (cnt >= half) ? cnt - half : cnt + half;
    if (!neg) return cnt < cmp;
    else if (tri_s) return cnt > top - cmp;
    else return s < cmp;
  endfunction

  // Dead time raised to the minimum when variable
  function automatic logic [15:0] clamp(input logic [15:0] dt, input logic [15:0] mn,
                                        input logic var_on);
    return (var_on && dt < mn) ? mn : dt;
  endfunction

  // Byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = wd[i*8 +: 8];
    end
    return r;
  endfunction

  localparam logic [15:0] PERIOD_RST = round_div(SYS_CLK_HZ, CARRIER_HZ);

  logic [15:0] ctrl_q;
  logic [15:0] period_q;
  logic [15:0] mod_a_q;
  logic [15:0] mod_b_q;
  logic [11:0] action_q;
  logic [31:0] dt_a_q;
  logic [31:0] dt_b_q;
  logic [15:0] dt_min_q;
  logic [15:0] phase_q;
  logic [7:0]  trig_div_q;
  logic [16:0] seq_in_q;
  logic [31:0] rdata_q;
  logic        wait_q;
  logic [15:0] cnt_q;
  logic        dir_q;
  logic        aq_a_q;
  logic        aq_b_q;
  logic [2:0]  sync_sr_q;
  logic [2:0]  trip_sr_q;
  logic        sync_f_q;
  logic        sync_prev_q;
  logic        trip_f_q;
  logic [3:0]  tcnt_q [2];
  logic [1:0]  trig_q;
  logic        sync_out_q;
  logic        ch_a_q;
  logic        ch_a_oe_q;
  logic        ch_b_q;
  logic        ch_b_oe_q;

  // Bus decode and readback
  wire         req      = i_avs_read | i_avs_write;
  wire         wr_fire  = i_avs_write & ~wait_q;
  wire [31:0]  status_w = {11'h000, trip_f_q, sync_f_q, aq_b_q, aq_a_q, dir_q, cnt_q};
  wire [31:0]  seq_in_w = {15'h0000, seq_in_q};
  wire [31:0]  mux_w    =
    (i_avs_address == `PCG_OFS_CTRL)     ? {16'h0000, ctrl_q} :
    (i_avs_address == `PCG_OFS_PERIOD)   ? {16'h0000, period_q} :
    (i_avs_address == `PCG_OFS_MOD_A)    ? {16'h0000, mod_a_q} :
    (i_avs_address == `PCG_OFS_MOD_B)    ? {16'h0000, mod_b_q} :
    (i_avs_address == `PCG_OFS_ACTION)   ? {20'h00000, action_q} :
    (i_avs_address == `PCG_OFS_DT_A)     ? dt_a_q :
    (i_avs_address == `PCG_OFS_DT_B)     ? dt_b_q :
    (i_avs_address == `PCG_OFS_DT_MIN)   ? {16'h0000, dt_min_q} :
    (i_avs_address == `PCG_OFS_PHASE)    ? {16'h0000, phase_q} :
    (i_avs_address == `PCG_OFS_TRIG_DIV) ? {24'h000000, trig_div_q} :
    (i_avs_address == `PCG_OFS_SEQ_IN)   ? seq_in_w :
    (i_avs_address == `PCG_OFS_STATUS)   ? status_w : 32'h00000000;

  // Waitrequest drops one cycle after a request, data latched then
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h00000000;
    end else begin
      wait_q <= ~(req & wait_q);
      if (i_avs_read && wait_q) rdata_q <= mux_w;
    end
  end

  // Register writes at the accepting edge
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      ctrl_q     <= `PCG_RST_CTRL;
      period_q   <= PERIOD_RST;
      mod_a_q    <= `PCG_RST_ZERO;
      mod_b_q    <= `PCG_RST_ZERO;
      action_q   <= 12'h000;
      dt_a_q     <= 32'h00000000;
      dt_b_q     <= 32'h00000000;
      dt_min_q   <= `PCG_RST_ZERO;
      phase_q    <= `PCG_RST_ZERO;
      trig_div_q <= 8'h00;
      seq_in_q   <= 17'h00000;
    end else if (wr_fire) begin
      case (i_avs_address)
        `PCG_OFS_CTRL:     ctrl_q     <= 16'(merge({16'h0000, ctrl_q}, i_avs_writedata,
                                                   i_avs_byteenable));
        `PCG_OFS_PERIOD:   period_q   <= 16'(merge({16'h0000, period_q}, i_avs_writedata,
                                                   i_avs_byteenable));
        `PCG_OFS_MOD_A:    mod_a_q    <= 16'(merge({16'h0000, mod_a_q}, i_avs_writedata,
                                                   i_avs_byteenable));
        `PCG_OFS_MOD_B:    mod_b_q    <= 16'(merge({16'h0000, mod_b_q}, i_avs_writedata,
                                                   i_avs_byteenable));
        `PCG_OFS_ACTION:   action_q   <= 12'(merge({20'h00000, action_q}, i_avs_writedata,
                                                   i_avs_byteenable));
        `PCG_OFS_DT_A:     dt_a_q     <= merge(dt_a_q, i_avs_writedata, i_avs_byteenable);
        `PCG_OFS_DT_B:     dt_b_q     <= merge(dt_b_q, i_avs_writedata, i_avs_byteenable);
        `PCG_OFS_DT_MIN:   dt_min_q   <= 16'(merge({16'h0000, dt_min_q}, i_avs_writedata,
                                                   i_avs_byteenable));
        `PCG_OFS_PHASE:    phase_q    <= 16'(merge({16'h0000, phase_q}, i_avs_writedata,
                                                   i_avs_byteenable));
        `PCG_OFS_TRIG_DIV: trig_div_q <= 8'(merge({24'h000000, trig_div_q}, i_avs_writedata,
                                                  i_avs_byteenable));
        `PCG_OFS_SEQ_IN:   seq_in_q   <= 17'(merge(seq_in_w, i_avs_writedata,
                                                   i_avs_byteenable));
        default: ;
      endcase
    end
  end

  // Control fields
  wire         tri_s    = ctrl_q[`PCG_CTRL_SHAPE];
  wire         pol      = ctrl_q[`PCG_CTRL_POL];
  wire         var_dt   = ctrl_q[`PCG_CTRL_VAR_DT];
  pcg_mode_t   mode;
  pcg_seq_t    seq;
  assign mode = pcg_mode_t'(ctrl_q[`PCG_CTRL_MODE]);
  assign seq  = pcg_seq_t'(ctrl_q[`PCG_CTRL_SEQ]);
  wire         aq_mode  = (seq == PCG_SEQ_ACT);
  wire         neg      = (seq == PCG_SEQ_NEG) ||
                          (seq == PCG_SEQ_VAR && !($signed(seq_in_q[`PCG_SEQ_VAL]) > 0));

  // Carrier limits: ramp tops at period-1, triangle at half period
  wire [15:0]  top      = tri_s ? period_q >> 1 : period_q - 16'h0001;
  wire [15:0]  half     = period_q >> 1;
  wire [15:0]  span     = tri_s ? top : period_q;
  wire [15:0]  cmp_a    = scale(mod_a_q, span);
  wire [15:0]  cmp_b    = scale(mod_b_q, span);
  wire [15:0]  ph_cnt   = scale(phase_q, span);
  wire         under    = (cnt_q == 16'h0000);
  wire         over     = (cnt_q == top);

  // Pin inputs: three stages, change taken when stages two and three agree
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      sync_sr_q   <= 3'b000;
      trip_sr_q   <= 3'b000;
      sync_f_q    <= 1'b0;
      trip_f_q    <= 1'b0;
      sync_prev_q <= 1'b0;
    end else begin
      sync_sr_q   <= {sync_sr_q[1:0], i_sync};
      trip_sr_q   <= {trip_sr_q[1:0], i_prot_trip};
      if (sync_sr_q[1] == sync_sr_q[2]) sync_f_q <= sync_sr_q[2];
      if (trip_sr_q[1] == trip_sr_q[2]) trip_f_q <= trip_sr_q[2];
      sync_prev_q <= sync_f_q;
    end
  end

  wire         ext_sync = ctrl_q[`PCG_CTRL_EXT_SYNC];
  wire         sync_ev  = ext_sync & sync_f_q & ~sync_prev_q;

  // Carrier counter; external sync loads the phase offset
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      cnt_q <= 16'h0000;
      dir_q <= 1'b1;
    end else if (sync_ev) begin
      cnt_q <= ph_cnt;
      dir_q <= 1'b1;
    end else if (!tri_s) begin
      cnt_q <= (cnt_q >= top) ? 16'h0000 : cnt_q + 16'h0001;
      dir_q <= 1'b1;
    end else if (dir_q) begin
      if (cnt_q >= top) begin
        cnt_q <= (top == 16'h0000) ? top : top - 16'h0001;
        dir_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end else begin
      if (cnt_q == 16'h0000) begin
        cnt_q <= 16'h0001;
        dir_q <= 1'b1;
      end else begin
        cnt_q <= cnt_q - 16'h0001;
      end
    end
  end

  // Timebase and compare events for the action tables
  wire [5:0]   ev = {cmp_b == cnt_q && !dir_q && tri_s, cmp_b == cnt_q && (dir_q || !tri_s),
                     cmp_a == cnt_q && !dir_q && tri_s, cmp_a == cnt_q && (dir_q || !tri_s),
                     over, under};
  wire [11:0]  act_a_w  = action_q & `PCG_ACT_MASK_A;
  wire [11:0]  act_b_w  = action_q & `PCG_ACT_MASK_B;

  // Action-table channel states
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      aq_a_q <= 1'b0;
      aq_b_q <= 1'b0;
    end else begin
      aq_a_q <= act_step(aq_a_q, act_a_w, ev);
      aq_b_q <= act_step(aq_b_q, act_b_w, ev);
    end
  end

  // Ideal active levels before dead time
  wire         reg_a    = pattern(cnt_q, cmp_a, neg, tri_s, top, half);
  wire         reg_b    = pattern(cnt_q, cmp_b, neg, tri_s, top, half);
  wire         en_force = !aq_mode && ctrl_q[`PCG_CTRL_EN_PORT] &&
                          !seq_in_q[`PCG_SEQ_EN];
  wire         trip     = ctrl_q[`PCG_CTRL_PROT] & trip_f_q;
  wire         dual     = (mode == PCG_MODE_DUAL);
  wire         x_a      = (aq_mode ? aq_a_q : reg_a) & ~en_force;
  wire         x_b      = (aq_mode ? aq_b_q : reg_b) & ~en_force;
  wire         in_a     = x_a;
  wire         in_b     = dual ? x_b : ~x_a & ~en_force;

  // Dead time pairs: shared or per channel, raised to the minimum
  wire [31:0]  dt_b_src = (var_dt && ctrl_q[`PCG_CTRL_DT_PER]) ? dt_b_q : dt_a_q;
  wire [15:0]  rise_a   = clamp(dt_a_q[15:0], dt_min_q, var_dt);
  wire [15:0]  fall_b   = clamp(dt_b_src[31:16], dt_min_q, var_dt);
  wire [15:0]  dly_a    = dual ? 16'h0000 : rise_a;
  wire [15:0]  dly_b    = dual ? 16'h0000 : fall_b;
  logic        dt_a;
  logic        dt_b;

  pcg_edge_delay u_dly_a (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_level    (in_a),
    .i_delay    (dly_a),
    .o_level    (dt_a)
  );

  pcg_edge_delay u_dly_b (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_level    (in_b),
    .i_delay    (dly_b),
    .o_level    (dt_b)
  );

  // Pin levels and enables per mode, active level by polarity
  wire         oe_a     = (mode != PCG_MODE_OFF);
  wire         oe_b     = (mode == PCG_MODE_COMPL) || dual;
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      ch_a_q    <= 1'b0;
      ch_b_q    <= 1'b0;
      ch_a_oe_q <= 1'b0;
      ch_b_oe_q <= 1'b0;
    end else begin
      ch_a_q    <= ~((dt_a & ~trip) ^ pol);
      ch_b_q    <= ~((dt_b & ~trip & oe_b) ^ pol);
      ch_a_oe_q <= oe_a;
      ch_b_oe_q <= oe_b;
    end
  end

  // Trigger dividers: count qualifying events, pulse on reaching divisor
  wire [1:0]   tsel [2];
  wire [3:0]   tdiv [2];
  assign tsel[0] = ctrl_q[`PCG_CTRL_ADC_SEL];
  assign tsel[1] = ctrl_q[`PCG_CTRL_TASK_SEL];
  assign tdiv[0] = trig_div_q[3:0];
  assign tdiv[1] = trig_div_q[7:4];
  wire [1:0]   qual = {(tsel[1][0] & under) | (tsel[1][1] & over),
                       (tsel[0][0] & under) | (tsel[0][1] & over)};

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      tcnt_q[0]  <= 4'h0;
      tcnt_q[1]  <= 4'h0;
      trig_q     <= 2'b00;
      sync_out_q <= 1'b0;
    end else begin
      for (int t = 0; t < 2; t++) begin
        trig_q[t] <= 1'b0;
        if (qual[t]) begin
          if (tcnt_q[t] + 4'h1 >= tdiv[t]) begin
            tcnt_q[t] <= 4'h0;
            trig_q[t] <= 1'b1;
          end else begin
            tcnt_q[t] <= tcnt_q[t] + 4'h1;
          end
        end
      end
      sync_out_q <= under;
    end
  end

  assign o_avs_readdata    = rdata_q;
  assign o_avs_waitrequest = wait_q;
  assign o_ch_a            = ch_a_q;
  assign o_ch_a_oe         = ch_a_oe_q;
  assign o_ch_b            = ch_b_q;
  assign o_ch_b_oe         = ch_b_oe_q;
  assign o_adc_trig        = trig_q[0];
  assign o_task_trig       = trig_q[1];
  assign o_sync_out        = sync_out_q;
endmodule

// ==== src/pcg_regs.svh ====
`ifndef PCG_REGS_SVH
`define PCG_REGS_SVH
// Register byte offsets
`define PCG_OFS_CTRL      6'h00
`define PCG_OFS_PERIOD    6'h04
`define PCG_OFS_MOD_A     6'h08
`define PCG_OFS_MOD_B     6'h0C
`define PCG_OFS_ACTION    6'h10
`define PCG_OFS_DT_A      6'h14
`define PCG_OFS_DT_B      6'h18
`define PCG_OFS_DT_MIN    6'h1C
`define PCG_OFS_PHASE     6'h20
`define PCG_OFS_TRIG_DIV  6'h24
`define PCG_OFS_SEQ_IN    6'h28
`define PCG_OFS_STATUS    6'h2C
// Control field positions
`define PCG_CTRL_SHAPE    0
`define PCG_CTRL_MODE     2:1
`define PCG_CTRL_SEQ      4:3
`define PCG_CTRL_POL      5
`define PCG_CTRL_EN_PORT  6
`define PCG_CTRL_VAR_DT   7
`define PCG_CTRL_DT_PER   8
`define PCG_CTRL_EXT_SYNC 9
`define PCG_CTRL_PROT     10
`define PCG_CTRL_ADC_SEL  12:11
`define PCG_CTRL_TASK_SEL 14:13
// Action word fields: zero, period, first up/down, second up/down
`define PCG_ACT_ZRO       1:0
`define PCG_ACT_PRD       3:2
`define PCG_ACT_CAU       5:4
`define PCG_ACT_CAD       7:6
`define PCG_ACT_CBU       9:8
`define PCG_ACT_CBD       11:10
`define PCG_ACT_MASK_A    12'h0FF
`define PCG_ACT_MASK_B    12'hF0F
// Sequence input fields
`define PCG_SEQ_VAL       15:0
`define PCG_SEQ_EN        16
// Reset values
`define PCG_RST_CTRL      16'h0006
`define PCG_RST_ZERO      16'h0000
// Timing
`define PCG_SYS_CLK_HZ    100000000
`define PCG_CARRIER_HZ    20000
`endif

// ==== src/pcg_pkg.sv ====
package pcg_pkg;
  typedef enum logic [1:0] {
    PCG_MODE_COMPL,
    PCG_MODE_SINGLE,
    PCG_MODE_DUAL,
    PCG_MODE_OFF
  } pcg_mode_t;
  typedef enum logic [1:0] {
    PCG_SEQ_POS,
    PCG_SEQ_NEG,
    PCG_SEQ_VAR,
    PCG_SEQ_ACT
  } pcg_seq_t;
  typedef enum logic [1:0] {
    PCG_ACT_NONE,
    PCG_ACT_CLR,
    PCG_ACT_SET,
    PCG_ACT_TGL
  } pcg_act_t;
endpackage

// ==== src/pcg_edge_delay.sv ====
`timescale 1ns/100ps
// Delays rising edges of a level by a cycle count; falls pass at once
module pcg_edge_delay (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_level,
  input  wire logic [15:0] i_delay,
  output logic             o_level
);
  logic [15:0] cnt_q;
  logic        out_q;

  // Count while input high, release output once delay elapsed
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || !i_level) begin
      cnt_q <= 16'h0000;
      out_q <= 1'b0;
    end else if (!out_q) begin
      if (cnt_q >= i_delay) begin
        out_q <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end

  assign o_level = out_q;
endmodule

// ==== bench/pcg_top_sva.sv ====
`timescale 1ns/100ps
// Bus handshake and event pulse checks on the top ports
module pcg_top_sva (
  input wire logic        i_core_clk,
  input wire logic        i_rst_n,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  input wire logic        o_adc_trig,
  input wire logic        o_task_trig,
  input wire logic        o_sync_out
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // Request seen while the slave still waits
  wire take_w = (i_avs_read || i_avs_write) && o_avs_waitrequest;
  property p_take; take_w |=> !o_avs_waitrequest; endproperty
  property p_one; !o_avs_waitrequest |=> o_avs_waitrequest; endproperty
  property p_idle; !take_w |=> o_avs_waitrequest; endproperty
  property p_hold;
    !(i_avs_read && o_avs_waitrequest) |=> $stable(o_avs_readdata);
  endproperty
  property p_rst; $rose(i_rst_n) |-> o_avs_waitrequest && !o_sync_out; endproperty
  property p_adc; o_adc_trig |=> !o_adc_trig; endproperty
  property p_task; o_task_trig |=> !o_task_trig; endproperty
  property p_sync; o_sync_out |=> !o_sync_out; endproperty
  a_take: assert property (p_take) else $error("waitrequest not dropped");
  a_one: assert property (p_one) else $error("waitrequest low too long");
  a_idle: assert property (p_idle) else $error("waitrequest low without request");
  a_hold: assert property (p_hold) else $error("readdata moved without read");
  a_rst: assert property (p_rst) else $error("bad state after reset");
  a_adc: assert property (p_adc) else $error("adc trigger too long");
  a_task: assert property (p_task) else $error("task trigger too long");
  a_sync: assert property (p_sync) else $error("sync pulse too long");
  c_read: cover property (i_avs_read && !o_avs_waitrequest);
  c_adc: cover property (o_adc_trig);
  c_task: cover property (o_task_trig);
endmodule
bind pcg_top pcg_top_sva u_sva (.i_core_clk, .i_rst_n, .i_avs_read, .i_avs_write,
  .o_avs_readdata, .o_avs_waitrequest, .o_adc_trig, .o_task_trig, .o_sync_out);

// ==== bench/pcg_gate_drv.sv ====
`timescale 1ns/100ps
// Gate driver inputs: pulled down when the pin is released
module pcg_gate_drv (
  input  wire logic  i_core_clk,
  input  wire logic  i_a,
  input  wire logic  i_a_oe,
  input  wire logic  i_b,
  input  wire logic  i_b_oe,
  output logic [15:0] o_cnt_a,
  output logic [15:0] o_cnt_b
);
  wire gate_a = i_a_oe ? i_a : 1'b0; // Pull-down on a released pin
  wire gate_b = i_b_oe ? i_b : 1'b0;
  logic [15:0] cnt_a_q = 16'h0000;
  logic [15:0] cnt_b_q = 16'h0000;
  // Free-running count of cycles each gate is on
  always @(posedge i_core_clk) begin
    cnt_a_q <= cnt_a_q + {15'h0000, gate_a};
    cnt_b_q <= cnt_b_q + {15'h0000, gate_b};
  end
  assign o_cnt_a = cnt_a_q;
  assign o_cnt_b = cnt_b_q;
endmodule

// ==== bench/test_pwm_carrier_generator.sv ====
`timescale 1ns/100ps
module test_pwm_carrier_generator;
  logic        i_core_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic [5:0]  adr = 6'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdat = 32'h00000000;
  logic        trip_in = 1'b0;
  logic        sync_in = 1'b0;
  logic [31:0] rdat, rv;
  logic        wait_r, a, a_oe, b, b_oe, adc, tsk, syn;
  logic [15:0] ga, gb, da, db;
  int          err_count = 0;
  int          check_count = 0;
  int          n_adc, n_tsk, n_syn;
  always #5 i_core_clk = ~i_core_clk;
  pcg_top #(.CARRIER_HZ(10000000)) DUT (.i_core_clk, .i_rst_n, .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wait_r), .i_sync(sync_in), .i_prot_trip(trip_in),
    .o_ch_a(a), .o_ch_a_oe(a_oe), .o_ch_b(b), .o_ch_b_oe(b_oe), .o_adc_trig(adc),
    .o_task_trig(tsk), .o_sync_out(syn));
  pcg_gate_drv GD (.i_core_clk, .i_a(a), .i_a_oe(a_oe), .i_b(b), .i_b_oe(b_oe),
    .o_cnt_a(ga), .o_cnt_b(gb));
  task automatic check(string nm, logic [31:0] got, logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic results();
    if (err_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // One Avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] ad, input logic [31:0] d);
    int k;
    @(posedge i_core_clk);
    adr <= ad;
    wdat <= d;
    wr <= w;
    rd <= !w;
    for (k = 0; k < 50; k++) begin
      @(posedge i_core_clk);
      if (wait_r === 1'b0) break;
    end
    if (k == 50) begin
      err_count++;
      results();
    end
    rv = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  // Settle through two sync pulses, then count over 32 cycles
  task automatic meas(input logic [31:0] ctrl);
    int k;
    logic [15:0] a0, b0;
    bus(1'b1, 6'h00, ctrl);
    repeat (2) begin
      for (k = 0; k < 100 && syn !== 1'b1; k++) @(posedge i_core_clk);
      if (k == 100) begin
        err_count++;
        results();
      end
      @(posedge i_core_clk);
    end
    a0 = ga;
    b0 = gb;
    n_adc = 0;
    n_tsk = 0;
    n_syn = 0;
    repeat (32) begin
      @(posedge i_core_clk);
      n_adc += int'(adc === 1'b1);
      n_tsk += int'(tsk === 1'b1);
      n_syn += int'(syn === 1'b1);
    end
    da = ga - a0;
    db = gb - b0;
  endtask
  task automatic t_reset();
    bus(1'b0, 6'h00, 32'h0);
    check("ctrl reset", rv, 32'h00000006);
    bus(1'b0, 6'h04, 32'h0);
    check("period reset", rv, 32'h0000000A);
    bus(1'b1, 6'h30, 32'hFFFFFFFF);
    bus(1'b0, 6'h30, 32'h0);
    check("unmapped", rv, 32'h00000000);
  endtask
  task automatic t_seq();
    bus(1'b1, 6'h04, 32'h00000008);
    bus(1'b1, 6'h08, 32'h00004000);
    meas(32'h00000022);
    check("single duty", da, 16'h0008);
    check("single b oe", b_oe, 1'b0);
    check("sync count", n_syn, 32'h4);
    check("start active", a, 1'b1);
    meas(32'h0000002A);
    check("negative duty", da, 16'h0008);
    check("start passive", a, 1'b0);
    meas(32'h00000002);
    check("low polarity", da, 16'h0018);
  endtask
  task automatic t_modes();
    bus(1'b1, 6'h0C, 32'h00004000);
    meas(32'h00000020);
    check("compl a", da, 16'h0008);
    check("compl b", db, 16'h0018);
    meas(32'h00000024);
    check("dual b", db, 16'h0008);
    meas(32'h00000026);
    check("off a", da, 16'h0000);
    check("off oe", {a_oe, b_oe}, 2'b00);
  endtask
  task automatic t_enable();
    bus(1'b1, 6'h28, 32'h00000000);
    meas(32'h00000062);
    check("enable zero", da, 16'h0000);
    bus(1'b1, 6'h28, 32'h00010000);
    meas(32'h00000062);
    check("enable one", da, 16'h0008);
  endtask
  task automatic t_trig();
    meas(32'h00004822);
    check("adc under", n_adc, 32'h4);
    check("task over", n_tsk, 32'h4);
    meas(32'h00003823);
    check("adc both", n_adc, 32'h8);
    bus(1'b1, 6'h24, 32'h00000002);
    meas(32'h00003823);
    check("adc div", n_adc, 32'h4);
    check("task tri", n_tsk, 32'h4);
  endtask
  // Action table: zero sets, first compare up clears, second compare up toggles
  task automatic t_action();
    bus(1'b1, 6'h08, 32'h00008000);
    bus(1'b1, 6'h10, 32'h00000012);
    bus(1'b1, 6'h28, 32'h00000000);
    meas(32'h0000007A);
    check("table a", da, 16'h0010);
    bus(1'b1, 6'h10, 32'h00000312);
    meas(32'h0000007C);
    check("table a masked", da, 16'h0010);
    check("table b dual", db, 16'h0008);
    meas(32'h00000078);
    check("table b compl", db, 16'h0010);
  endtask
  // Variable sequence: level at carrier zero shows the chosen sequence
  task automatic t_vseq();
    bus(1'b1, 6'h28, 32'h00000001);
    meas(32'h00000032);
    check("var positive", a, 1'b1);
    bus(1'b1, 6'h28, 32'h00000000);
    meas(32'h00000032);
    check("var zero", a, 1'b0);
  endtask
  // Trip coupling, then half-period phase load on an external sync edge
  task automatic t_pins();
    int k;
    trip_in <= 1'b1;
    meas(32'h00000422);
    check("trip passive", da, 16'h0000);
    meas(32'h00000022);
    check("trip ignored", da, 16'h0010);
    trip_in <= 1'b0;
    bus(1'b1, 6'h20, 32'h00008000);
    meas(32'h00000222);
    sync_in <= 1'b1;
    for (k = 1; k < 20; k++) begin
      @(posedge i_core_clk);
      if (syn === 1'b1) break;
    end
    check("sync phase", k, 32'h0000000B);
    sync_in <= 1'b0;
  endtask
  // Dead time: shared pair, minimum clamp, per-channel pair
  task automatic t_dead();
    bus(1'b1, 6'h14, 32'h00020002);
    meas(32'h00000020);
    check("dead a", da, 16'h0008);
    check("dead b", db, 16'h0008);
    bus(1'b1, 6'h1C, 32'h00000003);
    meas(32'h000000A0);
    check("min dead", da, 16'h0004);
    bus(1'b1, 6'h1C, 32'h00000000);
    bus(1'b1, 6'h18, 32'h00010000);
    meas(32'h000001A0);
    check("pair b", db, 16'h000C);
  endtask
  initial begin
    repeat (4) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    t_reset();
    t_seq();
    t_modes();
    t_enable();
    t_trig();
    t_action();
    t_vseq();
    t_pins();
    t_dead();
    results();
  end
endmodule
